// File: core/io_expander_pkg.sv
// Purpose: Shared constants for the 24-bit serial I/O expander.
// Assumes: One system clock; all link pins are asynchronous to it.
// Notes: Pin 1 maps to bit 0 of every parallel vector.
package io_expander_pkg;

  // ------------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------------
  localparam int unsigned PORT_WIDTH = 24;
  localparam int unsigned CNT_WIDTH = 5;
  localparam logic [PORT_WIDTH-1:0] LATCH_RESET = 24'hffffff;
  localparam logic [PORT_WIDTH-1:0] SHIFT_RESET = 24'hffffff;

  // Frame states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b10
  } frame_state_e;

endpackage

// File: core/pin_sync.sv
// Purpose: Two-stage synchronisers and edge detectors for link pins.
// Assumes: Pins are asynchronous to i_ref_clk.
// Notes: Edge detection looks only at the second stage and beyond.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_serial_in,
  input wire logic i_out_dis_n,
  pin_sync_if.src sync
);

  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic [1:0] prev_ff;
  wire [3:0] raw_pins = {i_out_dis_n, i_serial_in, i_sclk, i_cs_n};

  // Pins settle idle high so no false edge follows reset.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_ff <= 4'hf;
      sync_ff <= 4'hf;
      prev_ff <= 2'h3;
    end else begin
      meta_ff <= raw_pins;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff[1:0];
    end
  end

  // Edges are taken against the previous settled sample.
  assign sync.cs_n_lvl = sync_ff[0];
  assign sync.cs_fall = prev_ff[0] & ~sync_ff[0];
  assign sync.cs_rise = ~prev_ff[0] & sync_ff[0];
  assign sync.sclk_rise = ~prev_ff[1] & sync_ff[1];
  assign sync.sclk_fall = prev_ff[1] & ~sync_ff[1];
  assign sync.sdi_lvl = sync_ff[2];
  assign sync.oe_dis_n_lvl = sync_ff[3];

endmodule
`default_nettype wire

// File: core/pin_sync_if.sv
// Purpose: Carries synchronised link levels and edge pulses.
// Assumes: Driven by the synchroniser, read by the expander core.
// Notes: All signals are on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  logic cs_n_lvl;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic sdi_lvl;
  logic oe_dis_n_lvl;
  modport src (
    output cs_n_lvl, cs_fall, cs_rise, sclk_rise, sclk_fall, sdi_lvl,
    output oe_dis_n_lvl
  );
  modport dst (
    input cs_n_lvl, cs_fall, cs_rise, sclk_rise, sclk_fall, sdi_lvl,
    input oe_dis_n_lvl
  );
endinterface
`default_nettype wire

// File: core/serial_io_expander.sv
// Purpose: 24-bit serial I/O expander with open-drain port pins.
// Assumes: Host serial clock well below the system clock rate.
// Notes: Pins are open-drain; an enable low means pulling low.
//
// Notes on behaviour
// - Chip select fall snapshots all pins.
// - Output and input shifting start together.
// - Snapshot shifts out on clock falls.
// - Serial input sampled on clock rises.
// - Ignore clocks after 24; float output.
// - Chip select rise loads output latch.
// - Snapshot is pin level AND latch.
// - Early chip select rise still loads latch.
// - Written one releases pin; zero drives low.
// - All outputs only pull low or release.
// - Output disable floats every output.
`timescale 1ns/1ps
`default_nettype none
module serial_io_expander
  import io_expander_pkg::*;
#(
  parameter int unsigned WIDTH = PORT_WIDTH
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_serial_in,
  input wire logic i_out_dis_n,
  input wire logic [WIDTH-1:0] i_parallel_pins,
  output logic [WIDTH-1:0] o_parallel_pins,
  output logic [WIDTH-1:0] o_parallel_pins_oe_n,
  output logic o_serial_out,
  output logic o_serial_out_oe_n
);

  // ------------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------------
  pin_sync_if sync ();

  pin_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_cs_n(i_cs_n),
    .i_sclk(i_sclk),
    .i_serial_in(i_serial_in),
    .i_out_dis_n(i_out_dis_n),
    .sync(sync)
  );

  // Parallel pins are asynchronous too, so they pass two stages.
  logic [WIDTH-1:0] pin_meta_ff;
  logic [WIDTH-1:0] pin_sync_ff;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_meta_ff <= '1;
      pin_sync_ff <= '1;
    end else begin
      pin_meta_ff <= i_parallel_pins;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ------------------------------------------------------------------
  // Frame state and shift registers
  // ------------------------------------------------------------------
  frame_state_e state_ff;
  frame_state_e nxt_state;
  logic [CNT_WIDTH-1:0] out_cnt_ff;
  logic [CNT_WIDTH-1:0] in_cnt_ff;
  logic [WIDTH-1:0] snap_ff;
  logic [WIDTH-1:0] collect_ff;
  logic [WIDTH-1:0] latch_ff;
  logic sdo_ff;
  logic sdo_en_ff;

  localparam logic [CNT_WIDTH-1:0] LAST_BIT = CNT_WIDTH'(WIDTH);

  wire in_shift = (state_ff == ST_SHIFT);
  wire in_full = (in_cnt_ff == LAST_BIT);
  wire out_full = (out_cnt_ff == LAST_BIT);
  wire take_in = in_shift & sync.sclk_rise & ~in_full;
  wire take_out = in_shift & sync.sclk_fall & ~out_full;

  // Frame sequencing; DONE holds until chip select returns high.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (sync.cs_fall) begin
          nxt_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (sync.cs_rise) begin
          nxt_state = ST_IDLE;
        end else if (in_full && out_full) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (sync.cs_rise) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      snap_ff <= SHIFT_RESET;
      out_cnt_ff <= '0;
    end else if (state_ff == ST_IDLE && sync.cs_fall) begin
      snap_ff <= pin_sync_ff & latch_ff;
      out_cnt_ff <= '0;
    end else if (take_out) begin
      snap_ff <= {1'b1, snap_ff[WIDTH-1:1]};
      out_cnt_ff <= out_cnt_ff + 1'b1;
    end
  end

  // Bit 0 is the first bit out, so it drives the line on each fall until WIDTH bits are out.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sdo_ff <= 1'b1;
      sdo_en_ff <= 1'b0;
    end else if (take_out) begin
      sdo_ff <= snap_ff[0];
      sdo_en_ff <= 1'b1;
    end else if (!in_shift || (sync.sclk_fall && out_full)) begin
      sdo_ff <= 1'b1;
      sdo_en_ff <= 1'b0;
    end
  end

  // sample on rise
  // Shifting toward bit 0 puts the first bit in on pin one.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      collect_ff <= SHIFT_RESET;
      in_cnt_ff <= '0;
    end else if (state_ff == ST_IDLE && sync.cs_fall) begin
      in_cnt_ff <= '0;
    end else if (take_in) begin
      collect_ff <= {sync.sdi_lvl, collect_ff[WIDTH-1:1]};
      in_cnt_ff <= in_cnt_ff + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Output latch
  // ------------------------------------------------------------------
  // A short frame leaves its bits at the upper end of the collector.
  // They are moved down so the first lands on pin one, and pins never
  // written fill with ones, so a cut frame releases them, not pulls.
  wire [WIDTH-1:0] load_val = in_full ? collect_ff :
                              ~(~collect_ff >> (WIDTH - 32'(in_cnt_ff)));

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      latch_ff <= LATCH_RESET;
    end else if (sync.cs_rise && state_ff != ST_IDLE) begin
      latch_ff <= load_val;
    end
  end

  // ------------------------------------------------------------------
  // Open-drain drivers
  // ------------------------------------------------------------------
  // disable floats all
  assign o_parallel_pins = '0;
  assign o_parallel_pins_oe_n = sync.oe_dis_n_lvl ? latch_ff : '1;
  assign o_serial_out = 1'b0;
  assign o_serial_out_oe_n = ~(sync.oe_dis_n_lvl & sdo_en_ff & ~sdo_ff);

endmodule
`default_nettype wire

// File: verif/host_model.sv
// Purpose: Host that frames and clocks the serial link.
// Assumes: Link clock period of 80 ns, sampled by the system clock.
// Notes: Released data shows the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic i_sdo_line,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_serial_in
);
  // The link clock stands high between frames.
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_serial_in = 1'b0;
  end
  // full duplex frame
  // The line is sampled just before each rise, a half period after
  // the fall that shifted it, which covers the synchroniser lag.
  task automatic xfer(input logic [23:0] wr, input int n,
      output logic [23:0] rd, output logic hi);
    rd = '1;
    hi = 1'b1;
    o_cs_n = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      o_sclk = 1'b0;
      o_serial_in = (i < 24) ? wr[i] : ~o_serial_in;
      #40;
      if (i < 24) rd[i] = i_sdo_line;
      else hi &= i_sdo_line;
      o_sclk = 1'b1;
      #40;
    end
    #40;
    o_cs_n = 1'b1;
    o_serial_in = ~o_serial_in;
    #200;
  endtask
endmodule
`default_nettype wire

// File: verif/serial_io_expander_checker.sv
// Purpose: Port assertions for the serial I/O expander.
// Assumes: Outputs follow link edges within six reference clocks.
// Notes: Bound to every instance of the expander.
`timescale 1ns/1ps
`default_nettype none
module serial_io_expander_checker #(
  parameter int unsigned WIDTH = 24
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_serial_in,
  input wire logic i_out_dis_n,
  input wire logic [WIDTH-1:0] i_parallel_pins,
  input wire logic [WIDTH-1:0] o_parallel_pins,
  input wire logic [WIDTH-1:0] o_parallel_pins_oe_n,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe_n
);
  // Checks rest during reset; the disable lags by the synchroniser.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_dis; !i_out_dis_n [*5]; endsequence
  sequence s_idle; i_cs_n [*6]; endsequence
  property p_pd; o_parallel_pins == '0; endproperty
  property p_sd; o_serial_out == 1'b0; endproperty
  property p_dp; s_dis |-> &o_parallel_pins_oe_n; endproperty
  property p_ds; s_dis |-> o_serial_out_oe_n; endproperty
  property p_rf; $rose(i_cs_n) |-> ##[1:6] o_serial_out_oe_n; endproperty
  property p_if; s_idle |-> o_serial_out_oe_n; endproperty
  property p_fh;
    (!i_cs_n && i_out_dis_n) [*6] |-> $stable(o_parallel_pins_oe_n);
  endproperty
  property p_ih;
    (i_cs_n && i_out_dis_n) [*8] |-> $stable(o_parallel_pins_oe_n);
  endproperty
  a_pd: assert property (p_pd)
    else $error("pin data driven high");
  a_sd: assert property (p_sd)
    else $error("serial data driven high");
  a_dp: assert property (p_dp)
    else $error("pins driven while disabled");
  a_ds: assert property (p_ds)
    else $error("serial line driven while disabled");
  a_rf: assert property (p_rf)
    else $error("serial line held after select rise");
  a_if: assert property (p_if)
    else $error("serial line driven outside frame");
  a_fh: assert property (p_fh)
    else $error("pins changed inside frame");
  a_ih: assert property (p_ih)
    else $error("pins changed while idle");
endmodule
bind serial_io_expander serial_io_expander_checker #(.WIDTH(WIDTH)) i_chk (.*);
`default_nettype wire

// File: verif/testbench.sv
// Purpose: Self-checking bench for the serial I/O expander.
// Assumes: Inputs change on the falling edge of the system clock.
// Notes: Pins and serial line are open-drain with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import io_expander_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic dis_n = 1'b0;
  logic [PORT_WIDTH-1:0] ext = '1;
  logic [PORT_WIDTH-1:0] rd;
  logic hi;
  int mismatches = 0;
  int cmp_count = 0;
  wire logic cs_n, sclk, sdi, so, so_oe_n, line;
  wire logic [PORT_WIDTH-1:0] po, po_oe_n, pins;
  // A wire is low while any party pulls it low.
  assign pins = ext & (po_oe_n | po);
  assign line = so_oe_n | so;
  always #5 i_ref_clk = ~i_ref_clk;
  host_model i_host_model (.i_sdo_line(line), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_serial_in(sdi));
  serial_io_expander #(.WIDTH(PORT_WIDTH)) i_serial_io_expander (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_serial_in(sdi), .i_out_dis_n(dis_n), .i_parallel_pins(pins),
    .o_parallel_pins(po), .o_parallel_pins_oe_n(po_oe_n),
    .o_serial_out(so), .o_serial_out_oe_n(so_oe_n));
  task automatic chk(input logic [PORT_WIDTH-1:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Written bits drive pins; the snapshot ANDs pins with the latch.
  task automatic t_full();
    i_host_model.xfer(24'h5a0f33, 24, rd, hi);
    chk(po_oe_n, 24'h5a0f33);
    ext = 24'hf0f0f0;
    repeat (20) @(negedge i_ref_clk);
    i_host_model.xfer(24'hffffff, 24, rd, hi);
    chk(rd, 24'h500030);
  endtask
  // Pulses past the 24th must change nothing and leave the line high.
  task automatic t_extra();
    ext = '1;
    repeat (20) @(negedge i_ref_clk);
    i_host_model.xfer(24'h00ff00, 28, rd, hi);
    chk(rd, 24'hffffff);
    chk(hi, 1'b1);
    chk(po_oe_n, 24'h00ff00);
  endtask
  // An early select rise still loads the bits taken so far.
  task automatic t_short();
    i_host_model.xfer(24'h0000a5, 8, rd, hi);
    chk(po_oe_n, 24'hffffa5);
    chk(so_oe_n, 1'b1);
  endtask
  // Disable floats the pins but keeps the latch.
  task automatic t_dis();
    dis_n = 1'b0;
    repeat (8) @(negedge i_ref_clk);
    chk(po_oe_n, 24'hffffff);
    dis_n = 1'b1;
    repeat (8) @(negedge i_ref_clk);
    chk(po_oe_n, 24'hffffa5);
  endtask
  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset, then lift the disable once outputs are known.
  initial begin
    repeat (5) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    repeat (10) @(negedge i_ref_clk);
    dis_n = 1'b1;
    repeat (10) @(negedge i_ref_clk);
    t_full();
    t_extra();
    t_short();
    t_dis();
    end_sim();
  end
  // A hang counts as a mismatch and ends the run.
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
